// File: rtl/kbd_link_pkg.sv
// Shared constants for the keyboard event link
package kbd_link_pkg;
   // Clock and serial timing
   localparam int CLK_HZ = 20_000_000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int BAUD = 9600;
   localparam int BIT_CYCLES_INT = CLK_HZ / BAUD;
   localparam logic [11:0] BIT_CYCLES = 12'(BIT_CYCLES_INT);
   localparam logic [11:0] HALF_BIT = 12'(BIT_CYCLES_INT / 2);
   localparam logic [3:0] FRAME_BITS_AFTER_START = 4'h9;
   localparam logic [3:0] RX_STOP_SLOT = 4'h9;
   localparam logic [3:0] RX_START_SLOT = 4'h0;

   // Velocity timebase: one tick per 100 us of key flight
   localparam int VEL_TICK_NS = 100_000;
   localparam int VEL_TICK_INT = (VEL_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] VEL_TICK_CYCLES = 12'(VEL_TICK_INT);
   localparam logic [7:0] VEL_MAX = 8'hFF;

   // Packet layout: byte 0 is a tag byte, followed by payload bytes
   localparam logic [2:0] TAG_KEY = 3'h4;
   localparam logic [2:0] TAG_CTRL = 3'h5;
   localparam logic [2:0] TAG_ALPHA = 3'h6;
   localparam logic [1:0] KEY_PKT_LEN = 2'h3;
   localparam logic [1:0] CTRL_PKT_LEN = 2'h2;
   localparam logic [1:0] ALPHA_PKT_LEN = 2'h2;

   // Display
   localparam int DISP_LEN = 12;
   localparam logic [3:0] DISP_LAST = 4'hB;
   localparam int CURSOR_CMD_BIT = 7;
   localparam logic [95:0] POWER_ON_TEXT = 96'h202D504F574552204F4E2D20; // " -POWER ON- "

   // Serial channels
   localparam int CH_ALPHA = 0;
   localparam int CH_HOST = 1;

   typedef enum logic [1:0]
   {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01,
      TX_WAIT = 2'b10
   } tx_state_e;
endpackage

// File: rtl/event_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
module event_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk, // System clock
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic in_valid, // Write request
   output logic in_ready, // Space available
   input wire logic [WIDTH-1:0] in_data, // Write data
   output logic out_valid, // Data available
   input wire logic out_ready, // Read accept
   output logic [WIDTH-1:0] out_data // Head entry
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("event_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // Full and empty from the occupancy count
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   // Storage
   always_ff @(posedge sys_clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   // Pointers and count
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule

// File: rtl/music_keyboard_event_link.sv
// Music keyboard event controller: key, control and alpha events framed to the host
// What this block does
// - Host link serial ports run at 9600 baud in both directions.
// - Report key down/up, alpha keys, fader moves and switch or pedal changes.
// - Every music key event goes out as exactly three bytes.
// - Key packet holds keyboard id, key index, press flag and velocity.
// - Velocity comes from flight time between first and second contact bar.
// - Eight-bit control values are sent only when different from the last.
// - Alpha characters are tagged, queued, and sent only when no key data waits.
// - After reset the display shows a fixed power-on message by itself.
// - Messages received from the host are shown on the display.
// - Alpha keyboard sends each keystroke as an ASCII asynchronous serial char.
// - Each side stops sending, once its current byte ends, while the other holds its enable line low.
module music_keyboard_event_link #(
   parameter int NUM_CTRL = 8, // Faders, switches and pedals
   parameter int FIFO_DEPTH = 8, // Alpha character queue depth
   parameter logic [3:0] KEYBOARD_ID = 4'h0 // Identifier sent in key packets
) (
   input wire logic sys_clk, // 20 MHz clock
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic [6:0] key_index, // Key whose contact is moving
   input wire logic key_press, // 1 = key going down, 0 = coming up
   input wire logic key_leave, // Pulse: contact left its first bar
   input wire logic key_arrive, // Pulse: contact reached its second bar
   input wire logic ctrl_valid, // Pulse: converted control value present
   input wire logic [2:0] ctrl_chan, // Control channel of that value
   input wire logic [7:0] ctrl_value, // Eight-bit converted position
   input wire logic alpha_rxd, // Serial in from alpha keyboard
   input wire logic host_rxd, // Serial in from host
   output logic host_txd, // Serial out to host
   input wire logic host_tx_enable, // Host allows our sending
   output logic kbd_rx_enable, // We allow host sending
   output logic [95:0] display_text, // 12 characters, leftmost in top byte
   output logic alpha_overrun // Pulse: alpha char lost, queue full
);
   initial
   begin
      if (NUM_CTRL < 1 || NUM_CTRL > 8)
         $error("music_keyboard_event_link: NUM_CTRL must be 1 to 8");
   end

   // ---------------- Serial receivers (alpha keyboard and host) ----------
   logic [1:0] rx_line;
   logic [1:0] rx_busy;
   logic [1:0][11:0] rx_cnt;
   logic [1:0][3:0] rx_slot;
   logic [1:0][7:0] rx_sh;
   logic [1:0] rx_done;
   logic [1:0][7:0] rx_byte;

   assign rx_line = {host_rxd, alpha_rxd};

   // One 8N1 receiver per channel, sampling mid-bit
   for (genvar g = 0; g < 2; g++)
   begin : g_rx
      always_ff @(posedge sys_clk or negedge reset_n)
      begin
         if (!reset_n)
         begin
            rx_busy[g] <= 1'b0;
            rx_cnt[g] <= '0;
            rx_slot[g] <= '0;
            rx_sh[g] <= '0;
            rx_done[g] <= 1'b0;
            rx_byte[g] <= '0;
         end
         else
         begin
            rx_done[g] <= 1'b0;
            if (!rx_busy[g])
            begin
               if (!rx_line[g])
               begin
                  rx_busy[g] <= 1'b1;
                  rx_cnt[g] <= kbd_link_pkg::HALF_BIT;
                  rx_slot[g] <= kbd_link_pkg::RX_START_SLOT;
               end
            end
            else if (rx_cnt[g] != '0)
               rx_cnt[g] <= rx_cnt[g] - 1'b1;
            else
            begin
               rx_cnt[g] <= kbd_link_pkg::BIT_CYCLES - 1'b1;
               rx_slot[g] <= rx_slot[g] + 1'b1;
               if (rx_slot[g] == kbd_link_pkg::RX_START_SLOT && rx_line[g])
                  rx_busy[g] <= 1'b0; // Glitch, not a start bit
               else if (rx_slot[g] == kbd_link_pkg::RX_STOP_SLOT)
               begin
                  rx_busy[g] <= 1'b0;
                  rx_done[g] <= rx_line[g]; // Framing error drops the byte
                  rx_byte[g] <= rx_sh[g];
               end
               else if (rx_slot[g] != kbd_link_pkg::RX_START_SLOT)
                  rx_sh[g] <= {rx_line[g], rx_sh[g][7:1]};
            end
         end
      end
   end

   // ---------------- Alpha character queue ---------------------------
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [7:0] fifo_out_data;

   event_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_alpha_fifo (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .in_valid(rx_done[kbd_link_pkg::CH_ALPHA]),
      .in_ready(fifo_in_ready),
      .in_data(rx_byte[kbd_link_pkg::CH_ALPHA]),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // A character that finds the queue full is lost and flagged
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         alpha_overrun <= 1'b0;
      else
         alpha_overrun <= rx_done[kbd_link_pkg::CH_ALPHA] && !fifo_in_ready;
   end

   // ---------------- Key flight timing --------------------------------
   logic flight_run;
   logic [11:0] vel_div;
   logic [7:0] flight_ticks;
   logic key_pend;
   logic key_take;
   logic [6:0] key_idx_q;
   logic key_press_q;
   logic [7:0] key_vel;

   // Flight timer counts 100 us ticks between the two bars, saturating
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         flight_run <= 1'b0;
         vel_div <= '0;
         flight_ticks <= '0;
      end
      else if (key_leave)
      begin
         flight_run <= 1'b1;
         vel_div <= kbd_link_pkg::VEL_TICK_CYCLES - 1'b1;
         flight_ticks <= '0;
      end
      else if (key_arrive)
         flight_run <= 1'b0;
      else if (flight_run)
      begin
         if (vel_div != '0)
            vel_div <= vel_div - 1'b1;
         else
         begin
            vel_div <= kbd_link_pkg::VEL_TICK_CYCLES - 1'b1;
            if (flight_ticks != kbd_link_pkg::VEL_MAX)
               flight_ticks <= flight_ticks + 1'b1;
         end
      end
   end

   // Key event latch; a new event in the take cycle is kept
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         key_pend <= 1'b0;
         key_idx_q <= '0;
         key_press_q <= 1'b0;
         key_vel <= '0;
      end
      else
      begin
         if (key_take)
            key_pend <= 1'b0;
         if (key_leave)
         begin
            key_idx_q <= key_index;
            key_press_q <= key_press;
         end
         if (key_arrive && flight_run)
         begin
            key_pend <= 1'b1;
            key_vel <= kbd_link_pkg::VEL_MAX - flight_ticks;
         end
      end
   end

   // ---------------- Control change detection --------------------------
   logic [NUM_CTRL-1:0][7:0] ctrl_last;
   logic ctrl_pend;
   logic ctrl_take;
   logic ctrl_accept;
   logic [2:0] ctrl_chan_q;
   logic [7:0] ctrl_val_q;

   // Only a changed value is accepted, and only when the slot is free
   assign ctrl_accept = ctrl_valid && !ctrl_pend && (32'(ctrl_chan) < NUM_CTRL)
      && (ctrl_value != ctrl_last[ctrl_chan]);

   // Last reported value per control
   for (genvar c = 0; c < NUM_CTRL; c++)
   begin : g_ctrl
      always_ff @(posedge sys_clk or negedge reset_n)
      begin
         if (!reset_n)
            ctrl_last[c] <= '0;
         else if (ctrl_accept && 32'(ctrl_chan) == c)
            ctrl_last[c] <= ctrl_value;
      end
   end

   // Pending control report
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_pend <= 1'b0;
         ctrl_chan_q <= '0;
         ctrl_val_q <= '0;
      end
      else if (ctrl_accept)
      begin
         ctrl_pend <= 1'b1;
         ctrl_chan_q <= ctrl_chan;
         ctrl_val_q <= ctrl_value;
      end
      else if (ctrl_take)
         ctrl_pend <= 1'b0;
   end

   // ---------------- Packet transmitter --------------------------------
   kbd_link_pkg::tx_state_e tx_state;
   logic [2:0][7:0] pkt;
   logic [1:0] pkt_len;
   logic [1:0] pkt_idx;
   logic [11:0] tx_cnt;
   logic [3:0] tx_bits;
   logic [8:0] tx_sh;
   logic start_pkt;
   logic byte_done;
   logic last_byte;
   logic load_byte;
   logic [2:0][7:0] new_pkt;
   logic [1:0] new_len;
   logic [7:0] load_val;
   logic alpha_take;

   // Source choice: key before control before alpha
   assign start_pkt = (tx_state == kbd_link_pkg::TX_IDLE) && host_tx_enable
      && (key_pend || ctrl_pend || fifo_out_valid);
   assign key_take = start_pkt && key_pend;
   assign ctrl_take = start_pkt && !key_pend && ctrl_pend;
   assign alpha_take = start_pkt && !key_pend && !ctrl_pend;
   assign fifo_out_ready = alpha_take;
   assign byte_done = (tx_state == kbd_link_pkg::TX_SEND) && (tx_cnt == '0) && (tx_bits == '0);
   assign last_byte = (pkt_idx == pkt_len - 1'b1);
   assign load_byte = start_pkt
      || ((byte_done && !last_byte || tx_state == kbd_link_pkg::TX_WAIT) && host_tx_enable);

   // Packet assembly for whichever source wins
   always_comb
   begin
      new_pkt = '0;
      new_len = kbd_link_pkg::ALPHA_PKT_LEN;
      if (key_pend)
      begin
         new_pkt[0] = {kbd_link_pkg::TAG_KEY, key_press_q, KEYBOARD_ID};
         new_pkt[1] = {1'b0, key_idx_q};
         new_pkt[2] = key_vel;
         new_len = kbd_link_pkg::KEY_PKT_LEN;
      end
      else if (ctrl_pend)
      begin
         new_pkt[0] = {kbd_link_pkg::TAG_CTRL, 2'b00, ctrl_chan_q};
         new_pkt[1] = ctrl_val_q;
         new_len = kbd_link_pkg::CTRL_PKT_LEN;
      end
      else
      begin
         new_pkt[0] = {kbd_link_pkg::TAG_ALPHA, 5'h00};
         new_pkt[1] = fifo_out_data;
      end
   end

   // Next byte to shift: first of a new packet, or the following byte
   always_comb
   begin
      if (start_pkt)
         load_val = new_pkt[0];
      else if (tx_state == kbd_link_pkg::TX_WAIT)
         load_val = pkt[pkt_idx];
      else
         load_val = pkt[pkt_idx + 1'b1];
   end

   // Framing state: idle, shifting a byte, or paused between bytes
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_state <= kbd_link_pkg::TX_IDLE;
         pkt <= '0;
         pkt_len <= '0;
         pkt_idx <= '0;
      end
      else
      begin
         if (start_pkt)
         begin
            pkt <= new_pkt;
            pkt_len <= new_len;
            pkt_idx <= '0;
         end
         else if (byte_done && !last_byte)
            pkt_idx <= pkt_idx + 1'b1;
         unique case (tx_state)
            kbd_link_pkg::TX_IDLE:
               if (start_pkt)
                  tx_state <= kbd_link_pkg::TX_SEND;
            kbd_link_pkg::TX_SEND:
               if (byte_done)
               begin
                  if (last_byte)
                     tx_state <= kbd_link_pkg::TX_IDLE;
                  else if (!host_tx_enable)
                     tx_state <= kbd_link_pkg::TX_WAIT;
               end
            kbd_link_pkg::TX_WAIT:
               if (host_tx_enable)
                  tx_state <= kbd_link_pkg::TX_SEND;
            default:
               tx_state <= kbd_link_pkg::TX_IDLE;
         endcase
      end
   end

   // Bit shifter at the baud rate; line idles high
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         host_txd <= 1'b1;
         tx_cnt <= '0;
         tx_bits <= '0;
         tx_sh <= '1;
      end
      else if (load_byte)
      begin
         host_txd <= 1'b0; // Start bit
         tx_sh <= {1'b1, load_val};
         tx_bits <= kbd_link_pkg::FRAME_BITS_AFTER_START;
         tx_cnt <= kbd_link_pkg::BIT_CYCLES - 1'b1;
      end
      else if (tx_state == kbd_link_pkg::TX_SEND)
      begin
         if (tx_cnt != '0)
            tx_cnt <= tx_cnt - 1'b1;
         else if (tx_bits != '0)
         begin
            host_txd <= tx_sh[0];
            tx_sh <= {1'b1, tx_sh[8:1]};
            tx_bits <= tx_bits - 1'b1;
            tx_cnt <= kbd_link_pkg::BIT_CYCLES - 1'b1;
         end
      end
      else
         host_txd <= 1'b1;
   end

   // ---------------- Message display -----------------------------------
   logic [kbd_link_pkg::DISP_LEN-1:0][7:0] disp;
   logic [3:0] cursor;
   logic [7:0] hbyte;

   assign hbyte = rx_byte[kbd_link_pkg::CH_HOST];

   // Host bytes: top bit set moves the cursor, else writes a character
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         disp <= kbd_link_pkg::POWER_ON_TEXT;
         cursor <= '0;
      end
      else if (rx_done[kbd_link_pkg::CH_HOST])
      begin
         if (hbyte[kbd_link_pkg::CURSOR_CMD_BIT])
         begin
            if (hbyte[3:0] <= kbd_link_pkg::DISP_LAST)
               cursor <= hbyte[3:0];
         end
         else
         begin
            disp[kbd_link_pkg::DISP_LAST - cursor] <= hbyte;
            cursor <= (cursor == kbd_link_pkg::DISP_LAST) ? 4'h0 : cursor + 1'b1;
         end
      end
   end

   assign display_text = disp;

   // We can always take host bytes, so sending is allowed once out of reset
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         kbd_rx_enable <= 1'b0;
      else
         kbd_rx_enable <= 1'b1;
   end
endmodule

// File: tb/music_keyboard_event_link_chk.sv
// Port checker for the keyboard event link
module music_keyboard_event_link_chk (
   input wire logic sys_clk, // Clock
   input wire logic reset_n, // Reset, active low
   input wire logic host_txd, // Serial out to host
   input wire logic host_rxd, // Serial in from host
   input wire logic alpha_rxd, // Serial in from alpha keyboard
   input wire logic host_tx_enable, // Host lets us send
   input wire logic kbd_rx_enable, // We let host send
   input wire logic [95:0] display_text, // Display characters
   input wire logic alpha_overrun // Alpha char lost
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BC = kbd_link_pkg::BIT_CYCLES_INT;
   localparam int RX_END = BC / 2 + 9 * BC;
   logic tb, tp;
   int tc, ts;
   logic [1:0] rl, rp, rb, re;
   int rc [2];
   int since [2];
   assign rl = {host_rxd, alpha_rxd}; // Index 1 is the host line, 0 the alpha line
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Frame position of the outgoing line and end of each incoming frame
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tb <= 1'b0;
         tp <= 1'b1;
         tc <= 0;
         ts <= 0;
         rb <= 2'h0;
         rp <= 2'h3;
         re <= 2'h0;
         rc <= '{0, 0};
         since <= '{15, 15};
      end
      else
      begin
         tp <= host_txd;
         rp <= rl;
         if (!tb && tp && !host_txd)
         begin
            tb <= 1'b1;
            tc <= 1;
            ts <= 0;
         end
         else if (tb)
         begin
            tc <= (tc == BC - 1) ? 0 : tc + 1;
            if (tc == BC - 1)
               ts <= ts + 1;
            if (tc == BC - 1 && ts == 9)
               tb <= 1'b0;
         end
         for (int i = 0; i < 2; i++)
         begin
            re[i] <= rb[i] && rc[i] == RX_END;
            since[i] <= re[i] ? 1 : (since[i] < 15 ? since[i] + 1 : 15);
            if (!rb[i] && rp[i] && !rl[i])
               rc[i] <= 1;
            else if (rb[i])
               rc[i] <= rc[i] + 1;
            if (!rb[i] && rp[i] && !rl[i])
               rb[i] <= 1'b1;
            else if (rb[i] && rc[i] == RX_END)
               rb[i] <= 1'b0;
         end
      end
   end
   sequence start_slot_s;
      tb && ts == 0;
   endsequence
   sequence stop_slot_s;
      tb && ts == 9;
   endsequence
   rx_en_on_a: assert property ($rose(reset_n) |=> kbd_rx_enable)
      else $error("receive enable not raised after reset");
   rx_en_hold_a: assert property (kbd_rx_enable |=> kbd_rx_enable)
      else $error("receive enable dropped");
   power_on_text_a: assert property ($rose(reset_n) |->
      display_text == kbd_link_pkg::POWER_ON_TEXT)
      else $error("power-on text missing");
   start_gate_a: assert property (!tb && $fell(host_txd) |-> $past(host_tx_enable))
      else $error("frame started while host disallowed sending");
   bit_edge_a: assert property (tb && $changed(host_txd) |-> tc == 0)
      else $error("serial out changed inside a bit");
   start_bit_a: assert property (start_slot_s |-> !host_txd)
      else $error("start bit not low");
   stop_bit_a: assert property (stop_slot_s |-> host_txd)
      else $error("stop bit not high");
   disp_cause_a: assert property ($changed(display_text) |->
      since[1] inside {[1:8]})
      else $error("display changed without a host byte");
   overrun_cause_a: assert property (alpha_overrun |-> since[0] inside {[1:8]})
      else $error("overrun without an alpha byte");
   overrun_pulse_a: assert property (alpha_overrun |=> !alpha_overrun)
      else $error("overrun longer than one cycle");
endmodule

bind music_keyboard_event_link music_keyboard_event_link_chk music_keyboard_event_link_chk_i (
   .sys_clk(sys_clk),
   .reset_n(reset_n),
   .host_txd(host_txd),
   .host_rxd(host_rxd),
   .alpha_rxd(alpha_rxd),
   .host_tx_enable(host_tx_enable),
   .kbd_rx_enable(kbd_rx_enable),
   .display_text(display_text),
   .alpha_overrun(alpha_overrun)
);

// File: tb/host_link_model.sv
// Behavioural host at the far end of the serial link
module host_link_model (
   input wire logic sys_clk, // Clock
   input wire logic host_txd, // Bytes from the keyboard
   output logic host_rxd, // Bytes to the keyboard
   output logic host_tx_enable // Lets the keyboard send
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BC = kbd_link_pkg::BIT_CYCLES_INT;
   logic [7:0] got [$];
   int frame_errs = 0;
   logic allow = 1'b0;
   assign host_tx_enable = allow;
   initial host_rxd = 1'b1;
   // Send one byte, start bit first, data low bit first
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         host_rxd = f[i];
         repeat (BC) @(negedge sys_clk);
      end
   endtask
   // Collect bytes from the keyboard, sampling mid-bit
   initial
   begin
      logic [7:0] b;
      forever
      begin
         @(negedge host_txd);
         repeat (BC / 2) @(posedge sys_clk);
         if (host_txd !== 1'b0)
            frame_errs++;
         for (int i = 0; i < 8; i++)
         begin
            repeat (BC) @(posedge sys_clk);
            b[i] = host_txd;
         end
         repeat (BC) @(posedge sys_clk);
         if (host_txd !== 1'b1)
            frame_errs++;
         got.push_back(b);
      end
   end
endmodule

// File: tb/music_keyboard_event_link_test.sv
// Self-checking bench for the keyboard event link
module music_keyboard_event_link_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] KBD_ID = 4'h5; // Arbitrary identifier
   localparam int BC = kbd_link_pkg::BIT_CYCLES_INT;
   logic sys_clk = 1'b0;
   logic reset_n, key_press, key_leave, key_arrive, ctrl_valid, alpha_rxd;
   logic [6:0] key_index;
   logic [2:0] ctrl_chan;
   logic [7:0] ctrl_value;
   logic host_rxd, host_txd, host_tx_enable, kbd_rx_enable, alpha_overrun;
   logic [95:0] display_text;
   logic [7:0] exp_q [$];
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   always #25 sys_clk = ~sys_clk;
   music_keyboard_event_link #(.KEYBOARD_ID(KBD_ID)) music_keyboard_event_link_i (
      .sys_clk(sys_clk), .reset_n(reset_n), .key_index(key_index),
      .key_press(key_press), .key_leave(key_leave), .key_arrive(key_arrive),
      .ctrl_valid(ctrl_valid), .ctrl_chan(ctrl_chan), .ctrl_value(ctrl_value),
      .alpha_rxd(alpha_rxd), .host_rxd(host_rxd), .host_txd(host_txd),
      .host_tx_enable(host_tx_enable), .kbd_rx_enable(kbd_rx_enable),
      .display_text(display_text), .alpha_overrun(alpha_overrun));
   host_link_model host_link_model_i (.sys_clk(sys_clk), .host_txd(host_txd),
      .host_rxd(host_rxd), .host_tx_enable(host_tx_enable));
   // Compare and count
   task automatic check(input logic [95:0] seen, input logic [95:0] want);
      tests_run++;
      if (seen !== want)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   // Alpha keyboard sends one character
   task automatic alpha_send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         alpha_rxd = f[i];
         repeat (BC) @(negedge sys_clk);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 160000)
      begin
         fails++;
         final_report();
      end
   end
   // Main sequence
   initial
   begin
      logic [95:0] want;
      logic [7:0] a, h0, h1;
      logic [6:0] k;
      logic p, low_seen;
      int ticks, cur;
      reset_n = 1'b0;
      key_index = 7'h00;
      key_press = 1'b0;
      key_leave = 1'b0;
      key_arrive = 1'b0;
      ctrl_valid = 1'b0;
      ctrl_chan = 3'h0;
      ctrl_value = 8'h00;
      alpha_rxd = 1'b1;
      low_seen = 1'b0;
      void'($urandom(32'h8F1C4E4A));
      repeat (16) @(negedge sys_clk);
      reset_n = 1'b1;
      check(display_text, kbd_link_pkg::POWER_ON_TEXT);
      @(negedge sys_clk);
      check(96'(kbd_rx_enable), 96'h1);
      $display("test power_on done");
      // Key flight timed in whole velocity ticks plus half a tick
      k = 7'($urandom_range(0, 127));
      p = 1'($urandom_range(0, 1));
      ticks = $urandom_range(2, 4);
      key_index = k;
      key_press = p;
      key_leave = 1'b1;
      @(negedge sys_clk);
      key_leave = 1'b0;
      repeat (ticks * 2000 + 998) @(negedge sys_clk);
      key_arrive = 1'b1;
      @(negedge sys_clk);
      key_arrive = 1'b0;
      exp_q.push_back({kbd_link_pkg::TAG_KEY, p, KBD_ID});
      exp_q.push_back({1'b0, k});
      exp_q.push_back(8'(255 - ticks));
      // Unchanged control value zero must not be reported
      ctrl_chan = 3'($urandom_range(0, 7));
      ctrl_valid = 1'b1;
      @(negedge sys_clk);
      ctrl_valid = 1'b0;
      repeat (3000)
      begin
         @(negedge sys_clk);
         if (host_txd !== 1'b1)
            low_seen = 1'b1;
      end
      check(96'(low_seen), 96'h0);
      $display("test hold_off done");
      host_link_model_i.allow = 1'b1;
      a = 8'($urandom_range(32, 126));
      h0 = 8'($urandom_range(32, 126));
      h1 = 8'($urandom_range(32, 126));
      cur = $urandom_range(0, 10);
      exp_q.push_back(8'hC0);
      exp_q.push_back(a);
      // Alpha char and host message bytes arrive while the key packet goes out
      fork
         alpha_send(a);
         begin
            host_link_model_i.send_byte(8'h80 | 8'(cur));
            host_link_model_i.send_byte(h0);
            host_link_model_i.send_byte(h1);
         end
      join
      repeat (10) @(negedge sys_clk);
      want = kbd_link_pkg::POWER_ON_TEXT;
      want[95 - 8 * cur -: 8] = h0;
      want[87 - 8 * cur -: 8] = h1;
      check(display_text, want);
      $display("test display done");
      for (int w = 0; w < 120000 && host_link_model_i.got.size() < 5; w++)
         @(negedge sys_clk);
      check(96'(host_link_model_i.got.size()), 96'h5);
      for (int i = 0; i < 5 && i < host_link_model_i.got.size(); i++)
         check(96'(host_link_model_i.got[i]), 96'(exp_q[i]));
      check(96'(host_link_model_i.frame_errs), 96'h0);
      check(96'(alpha_overrun), 96'h0);
      $display("test packets done");
      final_report();
   end
endmodule
